// ---- iap_map.svh ----
`ifndef IAP_MAP_SVH
`define IAP_MAP_SVH
// Summary of operation
// (R1) Non-maskable request accepted regardless of enable flag, above all sources.
// (R2) Non-maskable accept: push status, push counter, clear enable and service flag.
// (R3) Non-maskable request during its handler waits for return plus one instruction.
// (R4) Several non-maskable requests during one handler collapse into one pending.
// (R5) Maskable source eligible with request 1, mask 0, and enable flag set.
// (R6) While service priority flag is 0, low priority requests are refused.
// (R7) Inside a non-maskable handler no non-maskable or maskable request is taken.
// (R8) Maskable latency 7 to 32 clocks high, 8 to 33 clocks low.
// (R9) A request raised before a divide waits for the divide to finish.
// (R10) High priority level wins; ties go to the fixed default order.
// (R11) Refused requests stay pending in their flags until acceptable.
// (R12) Maskable accept: push, clear enable, copy source priority, branch to vector.
// (R13) Interrupt return ends maskable or non-maskable handler and resumes program.
// (R14) Break always raises software interrupt with vector 003EH, clears enable.
// (R15) Break return is a separate instruction leaving a software handler.
// (R16) Nesting only after handler sets enable again, since accept clears it.
// (R17) Equal or higher priority nests; lower priority does not.
// (R18) Held requests taken after return and at least one main instruction.
// (R19) Non-maskable handler admits only break; others admit non-maskable and break.
// (R20) Service flag 0 while high priority handler runs, else 1.
// (R21) Each maskable source has a priority flag, 0 high, 1 low.
// (R22) Both returns restore the status word, enable and service flags included.
// (R23) Reset sets the status word to 02H.
// (R24) Reset sets all mask flags to ones.
// (R25) Default order ranks sources by index, lowest index first.
// (R26) Accept pulse and vector only at a boundary; request flag cleared then.
`define IAP_NSRC        8
`define IAP_IDX_W       3
`define IAP_ADDR_W      12
`define IAP_OFF_REQ     12'h000
`define IAP_OFF_MASK    12'h004
`define IAP_OFF_PRIO    12'h008
`define IAP_OFF_PSW     12'h00C
`define IAP_OFF_STAT    12'h010
`define IAP_PSW_IE      7
`define IAP_PSW_ISP     1
`define IAP_RST_PSW     8'h02
`define IAP_RST_MASK    8'hFF
`define IAP_RST_PRIO    8'hFF
`define IAP_RST_REQ     8'h00
`define IAP_VEC_NMI     16'h0004
`define IAP_VEC_MASK    16'h0006
`define IAP_VEC_BRK     16'h003E
`define IAP_LAT_MIN_HI  7
`define IAP_LAT_MIN_LO  8
`define IAP_LAT_MAX_HI  32
`define IAP_LAT_MAX_LO  33
`endif

// ---- iap_pkg.sv ----
`default_nettype none
package iap_pkg;
  typedef enum logic [1:0] {
    IAP_KIND_NONE,
    IAP_KIND_NMI,
    IAP_KIND_MASK,
    IAP_KIND_SOFT
  } iap_kind_t;
  typedef enum logic [1:0] {
    IAP_ST_IDLE,
    IAP_ST_PUSH_PSW,
    IAP_ST_PUSH_PC,
    IAP_ST_LOAD
  } iap_state_t;
endpackage
`default_nettype wire

// ---- iap_prio_pick.sv ----
`timescale 1ns/100ps
`default_nettype none
module iap_prio_pick #(
  parameter int N = 8,
  parameter int W = 3
) (
  input  wire logic [N-1:0] req,
  output logic              any,
  output logic [W-1:0]      idx
);
  // Scan downward so the lowest set index is left standing
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i); // R25
      end
    end
  end
endmodule // iap_prio_pick
`default_nettype wire

// ---- iap_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "iap_map.svh"
module iap_ctrl
  import iap_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`IAP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [`IAP_NSRC-1:0]   src_event,
  input  wire logic                   nmi_event,
  input  wire logic                   insn_done,
  input  wire logic                   insn_hold,
  input  wire logic                   insn_interrupt_return_instruction,
  input  wire logic                   insn_break_return_instruction,
  input  wire logic                   insn_brk,
  input  wire logic                   insn_ei,
  input  wire logic                   insn_di,
  input  wire logic [7:0]             stack_psw,
  output logic                        accept,
  output var iap_kind_t               accept_kind,
  output logic                        push_psw,
  output logic                        push_pc,
  output logic [7:0]                  push_data,
  output logic                        load_pc,
  output logic [15:0]                 vector,
  output logic                        ie_flag,
  output logic                        isp_flag,
  output logic                        nmi_active
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [`IAP_NSRC-1:0] req;
  logic [`IAP_NSRC-1:0] req_q;
  logic [`IAP_NSRC-1:0] mask;
  logic [`IAP_NSRC-1:0] prio;
  logic [7:0]           program_status_word;
  logic                 nmi_pend;
  logic                 nmi_run;
  iap_state_t           state;
  iap_kind_t            kind_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_acc   = psel & penable;
  wire apb_wr    = apb_acc & pwrite;
  wire sel_req   = (paddr == `IAP_OFF_REQ);
  wire sel_mask  = (paddr == `IAP_OFF_MASK);
  wire sel_prio  = (paddr == `IAP_OFF_PRIO);
  wire sel_psw   = (paddr == `IAP_OFF_PSW);
  wire sel_stat  = (paddr == `IAP_OFF_STAT);
  wire hit       = sel_req | sel_mask | sel_prio | sel_psw | sel_stat;
  wire wr_req    = apb_wr & sel_req;
  wire wr_mask   = apb_wr & sel_mask;
  wire wr_prio   = apb_wr & sel_prio;
  wire wr_psw    = apb_wr & sel_psw;
  wire [7:0] stat_word = {5'h00, (state != IAP_ST_IDLE), nmi_run, nmi_pend};
  wire [7:0] rd_byte =
      sel_req  ? req  :
      sel_mask ? mask :
      sel_prio ? prio :
      sel_psw  ? program_status_word  :
      sel_stat ? stat_word : 8'h00;

  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~hit;

  // Read data is caught in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Eligibility and selection
  // ----------------------------------------------------------------
  wire ie  = program_status_word[`IAP_PSW_IE];
  wire in_service_priority_flag = program_status_word[`IAP_PSW_ISP];
  // Returns and hold instructions let one more instruction run first
  wire defer = insn_hold | insn_interrupt_return_instruction | insn_break_return_instruction;
  wire at_bnd = insn_done & (state == IAP_ST_IDLE);
  // Low level needs the flag one cycle longer, giving the extra clock
  wire [`IAP_NSRC-1:0] elig_hi = req & ~mask & ~prio; // R5 R21
  wire [`IAP_NSRC-1:0] elig_lo =
      req & req_q & ~mask & prio & {`IAP_NSRC{in_service_priority_flag}}; // R6 R8 R17

  logic                 any_hi;
  logic                 any_lo;
  logic [`IAP_IDX_W-1:0] idx_hi;
  logic [`IAP_IDX_W-1:0] idx_lo;

  iap_prio_pick #(
    .N (`IAP_NSRC),
    .W (`IAP_IDX_W)
  ) u_pick_hi (
    .req (elig_hi),
    .any (any_hi),
    .idx (idx_hi)
  );

  iap_prio_pick #(
    .N (`IAP_NSRC),
    .W (`IAP_IDX_W)
  ) u_pick_lo (
    .req (elig_lo),
    .any (any_lo),
    .idx (idx_lo)
  );

  wire [`IAP_IDX_W-1:0] grant_idx = any_hi ? idx_hi : idx_lo; // R10
  wire grant_pr = ~any_hi;
  // Break is part of its own execution and cannot be masked
  wire take_soft = at_bnd & insn_brk; // R14 R19
  wire take_nmi  = at_bnd & ~insn_brk & ~defer & nmi_pend & ~nmi_run; // R1 R3 R7
  wire take_mask = at_bnd & ~insn_brk & ~defer & ~nmi_pend & ~nmi_run
                 & ie & (any_hi | any_lo); // R5 R7 R16 R18
  wire take_any  = take_soft | take_nmi | take_mask;
  wire [`IAP_NSRC-1:0] clr_bit =
      take_mask ? (`IAP_NSRC'(1) << grant_idx) : '0; // R26
  wire [15:0] vec_mask =
      `IAP_VEC_MASK + {12'h000, grant_idx, 1'b0};

  assign accept      = take_any; // R26
  assign accept_kind = take_soft ? IAP_KIND_SOFT :
                       take_nmi  ? IAP_KIND_NMI  :
                       take_mask ? IAP_KIND_MASK : IAP_KIND_NONE;

  // ----------------------------------------------------------------
  // Request, mask and priority flags
  // ----------------------------------------------------------------
  wire [`IAP_NSRC-1:0] req_base = wr_req ? pwdata[`IAP_NSRC-1:0] : req;
  // Set beats clear so an event in the clearing cycle survives
  wire [`IAP_NSRC-1:0] next_req = (req_base & ~clr_bit) | src_event; // R11

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req   <= `IAP_RST_REQ;
      req_q <= `IAP_RST_REQ;
      mask  <= `IAP_RST_MASK; // R24
      prio  <= `IAP_RST_PRIO;
    end else begin
      req   <= next_req;
      req_q <= req;
      if (wr_mask) mask <= pwdata[`IAP_NSRC-1:0];
      if (wr_prio) prio <= pwdata[`IAP_NSRC-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Non-maskable pending and in-handler flags
  // ----------------------------------------------------------------
  // A single pending bit merges repeated requests into one
  wire next_nmi_pend = nmi_event | (nmi_pend & ~take_nmi); // R4
  wire nmi_ret       = insn_done & insn_interrupt_return_instruction & nmi_run; // R13
  wire next_nmi_run  = take_nmi | (nmi_run & ~nmi_ret);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_pend <= 1'b0;
      nmi_run  <= 1'b0;
    end else begin
      nmi_pend <= next_nmi_pend;
      nmi_run  <= next_nmi_run;
    end
  end

  // ----------------------------------------------------------------
  // Program status word
  // ----------------------------------------------------------------
  logic [7:0] next_psw;
  always_comb begin
    next_psw = program_status_word;
    if (wr_psw) begin
      next_psw = pwdata[7:0];
    end
    if (insn_done & insn_ei) begin
      next_psw[`IAP_PSW_IE] = 1'b1;
    end
    if (insn_done & insn_di) begin
      next_psw[`IAP_PSW_IE] = 1'b0;
    end
    if (insn_done & (insn_interrupt_return_instruction | insn_break_return_instruction)) begin
      next_psw = stack_psw; // R22 R13 R15
    end
    if (take_any) begin
      next_psw[`IAP_PSW_IE] = 1'b0; // R2 R12 R14
    end
    if (take_nmi) begin
      next_psw[`IAP_PSW_ISP] = 1'b0; // R2
    end
    if (take_mask) begin
      next_psw[`IAP_PSW_ISP] = grant_pr; // R12 R20
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      program_status_word <= `IAP_RST_PSW; // R23
    end else begin
      program_status_word <= next_psw;
    end
  end

  assign ie_flag    = ie;
  assign isp_flag   = in_service_priority_flag;
  assign nmi_active = nmi_run;

  // ----------------------------------------------------------------
  // Entry sequence: status word, counter, vector
  // ----------------------------------------------------------------
  iap_state_t next_state;
  always_comb begin
    case (state)
      IAP_ST_IDLE:     next_state = take_any ? IAP_ST_PUSH_PSW : IAP_ST_IDLE;
      IAP_ST_PUSH_PSW: next_state = IAP_ST_PUSH_PC;
      IAP_ST_PUSH_PC:  next_state = IAP_ST_LOAD;
      IAP_ST_LOAD:     next_state = IAP_ST_IDLE;
      default:         next_state = IAP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= IAP_ST_IDLE;
      kind_q    <= IAP_KIND_NONE;
      push_data <= 8'h00;
      vector    <= 16'h0000;
    end else begin
      state <= next_state;
      if (take_any) begin
        kind_q    <= accept_kind;
        push_data <= program_status_word;
        vector    <= take_soft ? `IAP_VEC_BRK :
                     take_nmi  ? `IAP_VEC_NMI : vec_mask;
      end
    end
  end

  // Status word goes first, then the program counter
  assign push_psw = (state == IAP_ST_PUSH_PSW); // R2 R12
  assign push_pc  = (state == IAP_ST_PUSH_PC);
  assign load_pc  = (state == IAP_ST_LOAD);
  // A divide holds off insn_done, so acceptance waits with it (R9)

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic grant_pr_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_pr_q <= 1'b1;
    end else if (take_mask) begin
      grant_pr_q <= grant_pr;
    end
  end

  property p_bnd_only;
    @(posedge clk) disable iff (!reset_n)
      accept |-> insn_done;
  endproperty
  a_bnd_only: assert property (p_bnd_only) // R26
    else $error("accept outside boundary");

  property p_entry_seq;
    @(posedge clk) disable iff (!reset_n)
      accept |=> push_psw ##1 (push_pc && !push_psw) ##1 load_pc;
  endproperty
  a_entry_seq: assert property (p_entry_seq) // R2
    else $error("entry sequence broken");

  property p_nmi_flags;
    @(posedge clk) disable iff (!reset_n)
      (accept && accept_kind == IAP_KIND_NMI)
        |=> !ie_flag && !isp_flag && nmi_active && vector == `IAP_VEC_NMI;
  endproperty
  a_nmi_flags: assert property (p_nmi_flags) // R2
    else $error("nmi entry flags wrong");

  property p_mask_isp;
    @(posedge clk) disable iff (!reset_n)
      (accept && accept_kind == IAP_KIND_MASK)
        |=> !ie_flag && (isp_flag == grant_pr_q);
  endproperty
  a_mask_isp: assert property (p_mask_isp) // R12
    else $error("maskable entry flags wrong");

  property p_mask_needs_ie;
    @(posedge clk) disable iff (!reset_n)
      (accept && accept_kind == IAP_KIND_MASK) |-> ie_flag && !nmi_active;
  endproperty
  a_mask_needs_ie: assert property (p_mask_needs_ie) // R5
    else $error("maskable taken while disabled");

  property p_nmi_only_soft;
    @(posedge clk) disable iff (!reset_n)
      (accept && nmi_active) |-> accept_kind == IAP_KIND_SOFT;
  endproperty
  a_nmi_only_soft: assert property (p_nmi_only_soft) // R7
    else $error("nesting inside nmi handler");

  property p_defer;
    @(posedge clk) disable iff (!reset_n)
      (insn_done && (insn_interrupt_return_instruction || insn_break_return_instruction || insn_hold) && !insn_brk)
        |-> !accept;
  endproperty
  a_defer: assert property (p_defer) // R18
    else $error("accept right after return");

  property p_brk_vec;
    @(posedge clk) disable iff (!reset_n)
      (accept && accept_kind == IAP_KIND_SOFT)
        |=> vector == `IAP_VEC_BRK ##2 load_pc;
  endproperty
  a_brk_vec: assert property (p_brk_vec) // R14
    else $error("break vector wrong");

  property p_low_isp;
    @(posedge clk) disable iff (!reset_n)
      (accept && accept_kind == IAP_KIND_MASK && !isp_flag)
        |=> isp_flag == 1'b0 && grant_pr_q == 1'b0;
  endproperty
  a_low_isp: assert property (p_low_isp) // R6
    else $error("low priority taken during high handler");

  property p_nmi_kept;
    @(posedge clk) disable iff (!reset_n)
      nmi_event |=> nmi_pend;
  endproperty
  a_nmi_kept: assert property (p_nmi_kept) // R4
    else $error("nmi request lost");

  property p_req_clr;
    @(posedge clk) disable iff (!reset_n)
      (accept && accept_kind == IAP_KIND_MASK && !src_event[grant_idx])
        |=> !req[$past(grant_idx)];
  endproperty
  a_req_clr: assert property (p_req_clr) // R26
    else $error("request flag not cleared");

  c_nmi:  cover property (@(posedge clk) disable iff (!reset_n)
    accept && accept_kind == IAP_KIND_NMI);
  c_hi:   cover property (@(posedge clk) disable iff (!reset_n)
    accept && accept_kind == IAP_KIND_MASK && any_hi);
  c_lo:   cover property (@(posedge clk) disable iff (!reset_n)
    accept && accept_kind == IAP_KIND_MASK && !any_hi);
  c_soft: cover property (@(posedge clk) disable iff (!reset_n)
    accept && accept_kind == IAP_KIND_SOFT && nmi_active);

endmodule // iap_ctrl
`default_nettype wire

// ---- iap_seq_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module iap_seq_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       accept,
  input  wire logic       push_psw,
  input  wire logic [7:0] push_data,
  input  wire logic       load_pc,
  output logic            insn_done,
  output logic            insn_hold,
  output logic            insn_interrupt_return_instruction,
  output logic            insn_break_return_instruction,
  output logic            insn_brk,
  output logic            insn_ei,
  output logic            insn_di,
  output logic [7:0]      stack_psw
);
  logic [7:0] stk [0:7];
  logic [2:0] sp;
  initial begin
    {insn_done, insn_hold, insn_interrupt_return_instruction, insn_break_return_instruction} = 4'h0;
    {insn_brk, insn_ei, insn_di} = 3'h0;
    stack_psw = 8'h00;
    sp = 3'h0;
  end
  // ------------------------------------------------------------
  // Stack of saved status words
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (push_psw) begin
      stk[sp] <= push_data;
      sp      <= sp + 3'h1;
    end
  end
  // Op: 0 plain, 1 return, 2 break return, 3 break, 4 enable, 5 disable
  task automatic exec(input int op, output logic took);
    int k;
    insn_done <= 1'b1;
    insn_hold <= (op == 1 || op == 2 || op == 4 || op == 5);
    insn_interrupt_return_instruction <= (op == 1);
    insn_break_return_instruction <= (op == 2);
    insn_brk  <= (op == 3);
    insn_ei   <= (op == 4);
    insn_di   <= (op == 5);
    if (op == 1 || op == 2) begin
      stack_psw <= stk[sp - 3'h1];
      sp        <= sp - 3'h1;
    end
    @(posedge clk);
    took = accept;
    {insn_done, insn_hold, insn_interrupt_return_instruction, insn_break_return_instruction} <= 4'h0;
    {insn_brk, insn_ei, insn_di} <= 3'h0;
    // Popped word is gone once the boundary has passed
    stack_psw <= ~stack_psw;
    @(posedge clk);
    for (k = 0; k < 8 && took && load_pc !== 1'b1; k++)
      @(posedge clk);
  endtask
endmodule // iap_seq_model
`default_nettype wire

// ---- iap_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "iap_map.svh"
module iap_ctrl_tb;
  import iap_pkg::*;
  logic        clk, reset_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr, accept, push_psw, push_pc, load_pc;
  logic [7:0]  src_event, push_data, stack_psw;
  logic        nmi_event, insn_done, insn_hold, insn_interrupt_return_instruction, insn_break_return_instruction;
  logic        insn_brk, insn_ei, insn_di, ie_flag, isp_flag, nmi_active;
  logic [15:0] vector;
  iap_kind_t   accept_kind, acc_kind;
  int          n_fail, n_compared, cyc, c_psw, c_pc;
  localparam int NOP = 0, INTERRUPT_RETURN_INSTRUCTION = 1, BREAK_RETURN_INSTRUCTION = 2, BREAK_INSTRUCTION = 3, EI = 4, DI = 5;
  iap_ctrl i_iap_ctrl (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .nmi_event(nmi_event), .insn_done(insn_done),
    .insn_hold(insn_hold), .insn_interrupt_return_instruction(insn_interrupt_return_instruction), .insn_break_return_instruction(insn_break_return_instruction),
    .insn_brk(insn_brk), .insn_ei(insn_ei), .insn_di(insn_di),
    .stack_psw(stack_psw), .accept(accept), .accept_kind(accept_kind),
    .push_psw(push_psw), .push_pc(push_pc), .push_data(push_data),
    .load_pc(load_pc), .vector(vector), .ie_flag(ie_flag),
    .isp_flag(isp_flag), .nmi_active(nmi_active));
  iap_seq_model i_iap_seq_model (.clk(clk), .reset_n(reset_n),
    .accept(accept), .push_psw(push_psw), .push_data(push_data),
    .load_pc(load_pc), .insn_done(insn_done), .insn_hold(insn_hold),
    .insn_interrupt_return_instruction(insn_interrupt_return_instruction), .insn_break_return_instruction(insn_break_return_instruction), .insn_brk(insn_brk),
    .insn_ei(insn_ei), .insn_di(insn_di), .stack_psw(stack_psw));
  // ------------------------------------------------------------
  // Clock, monitor and timeout
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (accept) acc_kind <= accept_kind;
    if (push_psw) c_psw <= cyc;
    if (push_pc) c_pc <= cyc;
    if (cyc > 20000) begin
      n_fail = n_fail + 1;
      test_done();
    end
  end
  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ------------------------------------------------------------
  // Bus, event and instruction drivers
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic raise(input logic [7:0] s, input logic n);
    src_event <= s;
    nmi_event <= n;
    @(posedge clk);
    src_event <= 8'h00;
    nmi_event <= 1'b0;
    @(posedge clk);
  endtask
  task automatic step(input int op, input iap_kind_t k,
                      input logic [15:0] v);
    logic took;
    i_iap_seq_model.exec(op, took);
    chk(took, k != IAP_KIND_NONE);
    if (k != IAP_KIND_NONE) begin
      chk(acc_kind, k);
      chk(vector, v);
      chk(c_pc - c_psw, 1);
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(`IAP_OFF_REQ, 32'h0000_0000);
    rd(`IAP_OFF_MASK, 32'h0000_00FF);
    rd(`IAP_OFF_PRIO, 32'h0000_00FF);
    rd(`IAP_OFF_PSW, 32'h0000_0002);
    rd(`IAP_OFF_STAT, 32'h0000_0000);
    rd(12'h020, 32'h0000_0000);
    chk(rerr, 1'b1);
    chk({ie_flag, isp_flag}, 2'h1);
  endtask
  task automatic t_mask;
    apb(1'b1, `IAP_OFF_PRIO, 32'h0000_00EB);
    raise(8'h04, 1'b0);
    step(NOP, IAP_KIND_NONE, 16'h0);
    rd(`IAP_OFF_REQ, 32'h0000_0004);
    apb(1'b1, `IAP_OFF_MASK, 32'h0000_00AA);
    step(NOP, IAP_KIND_NONE, 16'h0);
    step(EI, IAP_KIND_NONE, 16'h0);
    step(NOP, IAP_KIND_MASK, 16'h000A);
    rd(`IAP_OFF_REQ, 32'h0000_0000);
    chk({ie_flag, isp_flag}, 2'h0);
  endtask
  task automatic t_nest;
    raise(8'h40, 1'b0);
    step(NOP, IAP_KIND_NONE, 16'h0);
    step(EI, IAP_KIND_NONE, 16'h0);
    step(NOP, IAP_KIND_NONE, 16'h0);
    raise(8'h10, 1'b0);
    step(NOP, IAP_KIND_MASK, 16'h000E);
    step(INTERRUPT_RETURN_INSTRUCTION, IAP_KIND_NONE, 16'h0);
    step(NOP, IAP_KIND_NONE, 16'h0);
    chk({ie_flag, isp_flag}, 2'h2);
    step(INTERRUPT_RETURN_INSTRUCTION, IAP_KIND_NONE, 16'h0);
    step(NOP, IAP_KIND_MASK, 16'h0012);
    chk(isp_flag, 1'b1);
  endtask
  task automatic t_tie;
    raise(8'h15, 1'b0);
    step(INTERRUPT_RETURN_INSTRUCTION, IAP_KIND_NONE, 16'h0);
    step(NOP, IAP_KIND_MASK, 16'h000A);
    step(INTERRUPT_RETURN_INSTRUCTION, IAP_KIND_NONE, 16'h0);
    step(NOP, IAP_KIND_MASK, 16'h000E);
    step(INTERRUPT_RETURN_INSTRUCTION, IAP_KIND_NONE, 16'h0);
    step(NOP, IAP_KIND_MASK, 16'h0006);
  endtask
  task automatic t_nmi;
    raise(8'h00, 1'b1);
    step(NOP, IAP_KIND_NMI, 16'h0004);
    chk({ie_flag, isp_flag, nmi_active}, 3'h1);
    raise(8'h04, 1'b1);
    raise(8'h00, 1'b1);
    step(EI, IAP_KIND_NONE, 16'h0);
    step(NOP, IAP_KIND_NONE, 16'h0);
    rd(`IAP_OFF_STAT, 32'h0000_0003);
    step(BREAK_INSTRUCTION, IAP_KIND_SOFT, 16'h003E);
    chk(ie_flag, 1'b0);
    step(BREAK_RETURN_INSTRUCTION, IAP_KIND_NONE, 16'h0);
    chk({ie_flag, nmi_active}, 2'h3);
    step(INTERRUPT_RETURN_INSTRUCTION, IAP_KIND_NONE, 16'h0);
    chk(nmi_active, 1'b0);
    step(NOP, IAP_KIND_NMI, 16'h0004);
    step(INTERRUPT_RETURN_INSTRUCTION, IAP_KIND_NONE, 16'h0);
    step(NOP, IAP_KIND_NONE, 16'h0);
    step(EI, IAP_KIND_NONE, 16'h0);
    step(DI, IAP_KIND_NONE, 16'h0);
    chk(ie_flag, 1'b0);
    step(NOP, IAP_KIND_NONE, 16'h0);
    rd(`IAP_OFF_REQ, 32'h0000_0004);
  endtask
  initial begin
    {reset_n, psel, penable, pwrite, nmi_event} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    src_event = 8'h00;
    {n_fail, n_compared, cyc, c_psw, c_pc} = {5{32'sd0}};
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_mask();
    t_nest();
    t_tie();
    t_nmi();
    test_done();
  end
endmodule // iap_ctrl_tb
`default_nettype wire
